// >>> verification/tb_i2c_slave_bus_protocol.sv
/* self-checking bench of the two-wire slave engine against a master model.
   assumes the engine samples both wires on CLOCK and answers as noted. */
`timescale 1ns/1ps
module tb_i2c_slave_bus_protocol;
    logic clock = 0;
    logic rst = 1;
    logic hold_req = 0;
    logic ten_bit = 0;
    logic accept = 1;
    logic [7:0] control = 8'h20;
    logic [7:0] own_addr = 8'h5B;
    logic [7:0] tx_data = 8'h00;
    logic m_scl_low, m_sda_low, stuck, rx_valid, start_seen, stop_seen, bus_active;
    twi_pkg::pins_s pins;
    twi_pkg::rx_byte_s rx;
    twi_pkg::rx_byte_s expq[$];
    int fails = 0;
    int total_checks = 0;
    int n_start = 0;
    int n_stop = 0;
    wire scl = !(m_scl_low | (pins.scl_oe & !pins.scl_o));
    wire sda = !(m_sda_low | (pins.sda_oe & !pins.sda_o));
    twi_slave #(.LOW_CYC(4), .HIGH_CYC(4)) i_twi_slave (.CLOCK(clock), .RST(rst), .CE(1'b1),
        .CONTROL(control), .HOLD_REQ(hold_req), .OWN_ADDR(own_addr), .TEN_BIT(ten_bit),
        .ACCEPT(accept), .TX_DATA(tx_data), .MASTER_SDA(1'b0), .MASTER_SCL(1'b0),
        .SCL_I(scl), .SDA_I(sda), .PINS(pins), .RX(rx), .RX_VALID(rx_valid),
        .START_SEEN(start_seen), .STOP_SEEN(stop_seen), .ARB_LOST(), .BUS_ACTIVE(bus_active));
    twi_master_model i_twi_master_model (.scl_low(m_scl_low), .sda_low(m_sda_low),
        .scl(scl), .sda(sda), .stuck(stuck));
    initial forever #2.5 clock = !clock;
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    always @(negedge clock) begin
        if (start_seen === 1'b1) n_start++;
        if (stop_seen === 1'b1) n_stop++;
        if (rx_valid === 1'b1 && expq.size() == 0) check("rx_extra", 1, 0);
        else if (rx_valid === 1'b1) check("rx", rx, expq.pop_front());
    end
    task automatic conclude();
        check("stretch_timeout", stuck, 0);
        check("rx_missing", 10'(expq.size()), 0);
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    task automatic halt();
        i_twi_master_model.stop();
        check("idle", {pins.scl_oe, pins.sda_oe, bus_active}, 0);
    endtask : halt
    task automatic xfer(input logic [7:0] a, input int n, input logic ok, input int hold);
        logic [7:0] d;
        logic [7:0] r;
        logic k;
        i_twi_master_model.start();
        if (ok) expq.push_back({a, 1'b1, a[0]});
        i_twi_master_model.byte_io(a, 1'b1, r, k);
        check("addr_ack", k, !ok);
        for (int i = 0; ok && i < n; i++) begin
            d = $urandom;
            if (a[0]) begin
                i_twi_master_model.byte_io(8'hFF, i == n - 1, r, k);
                check("rd_data", r, tx_data);
            end else begin
                expq.push_back({d, 2'b00});
                @(posedge clock);
                #1 hold_req = (hold == 1);
                control[7] = (hold == 2);
                fork
                    i_twi_master_model.byte_io(d, 1'b1, r, k);
                    begin
                        repeat (80) @(posedge clock);
                        if (hold != 0) check("scl_hold", scl, 0);
                        #1 hold_req = 0;
                        control[7] = 0;
                    end
                join
                check("wr_ack", k, 0);
            end
        end
        if (ok && a[0]) #14 check("sda_free", sda, 1);
    endtask : xfer
    initial begin
        repeat (60000) @(posedge clock);
        check("timeout", 1, 0);
        conclude();
    end
    initial begin
        void'($urandom(9));
        repeat (10) @(posedge clock);
        #1 rst = 0;
        tx_data = $urandom;
        repeat (4) @(posedge clock);
        xfer(8'h5A, 3, 1, 0);
        xfer(8'h5B, 2, 1, 0);
        halt();
        xfer(8'h5A, 1, 1, 1);
        halt();
        xfer(8'h5A, 1, 1, 2);
        halt();
        xfer(8'h3A, 0, 0, 0);
        halt();
        @(posedge clock);
        #1 accept = 0;
        xfer(8'h5A, 0, 0, 0);
        halt();
        @(posedge clock);
        #1 accept = 1;
        control = 8'h00;
        xfer(8'h5A, 0, 0, 0);
        halt();
        @(posedge clock);
        #1 control = 8'h20;
        ten_bit = 1;
        own_addr = 8'hF2;
        xfer(8'hF2, 0, 1, 0);
        halt();
        check("starts", 10'(n_start), 7);
        check("stops", 10'(n_stop), 6);
        conclude();
    end
endmodule : tb_i2c_slave_bus_protocol

// >>> verification/twi_master_model.sv
/* behavioural two-wire bus master that drives the slave engine.
   assumes pull-ups on both wires; it only pulls low or releases. */
`timescale 1ns/1ps
module twi_master_model (
    output logic scl_low,
    output logic sda_low,
    input wire logic scl,
    input wire logic sda,
    output logic stuck
);
    initial begin
        scl_low = 0;
        sda_low = 0;
        stuck = 0;
    end
    // link clock stands still between frames
    task automatic bit_io(input logic b, output logic r);
        int n;
        sda_low = !b;
        #16 scl_low = 0;
        n = 0;
        while (scl !== 1'b1 && n < 4000) begin
            #1 n++;
        end
        if (n >= 4000) stuck = 1;
        #32 r = sda;
        scl_low = 1;
        #16;
    endtask : bit_io
    task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx,
        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(last, ack);
    endtask : byte_io
    task automatic start();
        sda_low = 0;
        #16 scl_low = 0;
        #32 sda_low = 1;
        #32 scl_low = 1;
        #16;
    endtask : start
    task automatic stop();
        sda_low = 1;
        #16 scl_low = 0;
        #32 sda_low = 0;
        #64;
    endtask : stop
endmodule : twi_master_model

// >>> verilog/twi_consts.svh
/*
  shared constants for the two-wire slave engine: timing counts, bit positions.
  assumes the including file is compiled after the types package.
*/
`ifndef TWI_CONSTS_SVH
`define TWI_CONSTS_SVH
`define TWI_CLK_NS 5
`define TWI_LOW_NS 1300
`define TWI_HIGH_NS 600
`define TWI_LOW_CYC ((`TWI_LOW_NS + `TWI_CLK_NS - 1) / `TWI_CLK_NS)
`define TWI_HIGH_CYC ((`TWI_HIGH_NS + `TWI_CLK_NS - 1) / `TWI_CLK_NS)
`define TWI_TEN_PATTERN 5'h1E
`define TWI_ENABLE_BIT 5
`define TWI_HOLD_BIT 7
`define TWI_RESET_ADDR 8'h00
`endif

// >>> verilog/twi_pkg.sv
/*
  types of the two-wire slave engine.
  assumes nothing beyond a SystemVerilog compiler.
*/
package twi_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_ACK = 5'b00100,
        ST_DATA = 5'b01000,
        ST_IGNORE = 5'b10000
    } phase_e;
    typedef struct packed {
        logic [7:0] data;
        logic is_addr;
        logic read_dir;
    } rx_byte_s;
    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } pins_s;
endpackage : twi_pkg

// >>> verilog/twi_slave.sv
/*
  bit-level slave engine of a two-wire serial port with byte handshakes.
  assumes SCL/SDA are open-drain wires resolved outside; firmware drives the
  control inputs synchronously to CLOCK.
*/
`timescale 1ns/1ps
`include "twi_consts.svh"
module twi_slave #(
    parameter int LOW_CYC = `TWI_LOW_CYC,
    parameter int HIGH_CYC = `TWI_HIGH_CYC
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [7:0] CONTROL,
    input wire logic HOLD_REQ,
    input wire logic [7:0] OWN_ADDR,
    input wire logic TEN_BIT,
    input wire logic ACCEPT,
    input wire logic [7:0] TX_DATA,
    input wire logic MASTER_SDA,
    input wire logic MASTER_SCL,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output twi_pkg::pins_s PINS,
    output twi_pkg::rx_byte_s RX,
    output logic RX_VALID,
    output logic START_SEEN,
    output logic STOP_SEEN,
    output logic ARB_LOST,
    output logic BUS_ACTIVE
);
    logic [1:0] scl_sync, sda_sync;
    logic scl_q, sda_q;
    twi_pkg::phase_e phase, next_phase;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic reading, matched, first_ten, ack_drive, tx_drive, tx_bit;
    logic [15:0] low_cnt;
    logic [15:0] high_cnt;
    logic sync_pull;

    wire enable = CONTROL[`TWI_ENABLE_BIT];
    wire hold = HOLD_REQ | CONTROL[`TWI_HOLD_BIT];
    wire scl = scl_sync[1];
    wire sda = sda_sync[1];
    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    wire start_cond = scl & scl_q & sda_q & ~sda;
    wire stop_cond = scl & scl_q & ~sda_q & sda;
    wire [7:0] rx_full = {shift[6:0], sda};
    // header is judged on the byte already shifted in, not on the live line
    wire is_ten_hdr = shift[7:3] == `TWI_TEN_PATTERN;
    wire lost = MASTER_SDA & ~sda & scl_rise;

    function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] own);
        addr_hit = rx[7:1] == own[7:1];
    endfunction : addr_hit

    // header compares only A9:A8; firmware swaps in the low byte afterwards
    wire addr_match = TEN_BIT & is_ten_hdr & ~first_ten
        ? OWN_ADDR[2:1] == shift[2:1] : addr_hit(shift, OWN_ADDR);

    // sync first stage only feeds the second
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (CE) begin
            scl_sync <= {scl_sync[0], SCL_I};
            sda_sync <= {sda_sync[0], SDA_I};
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    always_comb begin
        next_phase = phase;
        case (phase)
            twi_pkg::ST_IDLE: next_phase = phase;
            twi_pkg::ST_ADDR: if (scl_fall && bit_cnt == 4'h8) begin
                next_phase = twi_pkg::ST_ACK;
            end
            twi_pkg::ST_ACK: if (scl_fall && bit_cnt == 4'h9) begin
                next_phase = matched ? twi_pkg::ST_DATA : twi_pkg::ST_IGNORE;
            end
            twi_pkg::ST_DATA: if (scl_fall && bit_cnt == 4'h8) begin
                next_phase = twi_pkg::ST_ACK;
            end
            twi_pkg::ST_IGNORE: next_phase = phase;
            default: next_phase = twi_pkg::ST_IDLE;
        endcase
        if (start_cond || lost) begin
            next_phase = twi_pkg::ST_ADDR;
        end
        if (stop_cond || !enable) begin
            next_phase = twi_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            phase <= twi_pkg::ST_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            reading <= 1'b0;
            matched <= 1'b0;
            first_ten <= 1'b0;
            ack_drive <= 1'b0;
            tx_drive <= 1'b0;
            tx_bit <= 1'b1;
            RX <= '0;
            RX_VALID <= 1'b0;
            START_SEEN <= 1'b0;
            STOP_SEEN <= 1'b0;
            ARB_LOST <= 1'b0;
        end else if (CE) begin
            phase <= next_phase;
            RX_VALID <= 1'b0;
            START_SEEN <= enable & start_cond;
            STOP_SEEN <= enable & stop_cond;
            ARB_LOST <= enable & lost;
            if (start_cond || lost || !enable || stop_cond) begin
                bit_cnt <= 4'h0;
                ack_drive <= 1'b0;
                tx_drive <= 1'b0;
                first_ten <= start_cond ? first_ten : 1'b0;
                reading <= 1'b0;
            end else if (phase != twi_pkg::ST_IDLE && phase != twi_pkg::ST_IGNORE) begin
                if (scl_rise) begin
                    if (bit_cnt < 4'h8) begin
                        shift <= rx_full;
                    end else if (reading && sda) begin
                        reading <= 1'b0;
                    end
                    bit_cnt <= bit_cnt + 4'h1;
                end
                if (scl_fall && bit_cnt == 4'h8) begin
                    if (phase == twi_pkg::ST_ADDR) begin
                        // 10-bit: header then low byte against a rewritten address
                        matched <= ACCEPT & addr_match;
                        first_ten <= TEN_BIT & is_ten_hdr & ~shift[0];
                        reading <= shift[0] & ~(TEN_BIT & ~first_ten);
                        RX <= '{data: shift, is_addr: 1'b1, read_dir: shift[0]};
                    end else begin
                        matched <= matched & ACCEPT;
                        RX <= '{data: shift, is_addr: 1'b0, read_dir: reading};
                    end
                    // bytes shifted out on a read are not received data: no strobe
                    RX_VALID <= ACCEPT
                        & (phase == twi_pkg::ST_ADDR ? addr_match : matched & ~reading);
                    ack_drive <= ~reading & ACCEPT
                        & (phase == twi_pkg::ST_ADDR ? addr_match : matched);
                    tx_drive <= 1'b0;
                end
                if (scl_fall && bit_cnt == 4'h9) begin
                    ack_drive <= 1'b0;
                    bit_cnt <= 4'h0;
                    tx_drive <= reading & matched;
                    tx_bit <= TX_DATA[7];
                    shift <= TX_DATA;
                end else if (scl_fall && tx_drive && bit_cnt < 4'h8) begin
                    // shift moves left on each of the eight bit rises, not the ack rise, so bit 7 is always next out
                    tx_bit <= shift[7];
                    tx_drive <= bit_cnt != 4'h8;
                end
            end
        end
    end

    // optional clock sync for firmware master assist
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            low_cnt <= 16'h0000;
            high_cnt <= 16'h0000;
            sync_pull <= 1'b0;
        end else if (CE) begin
            if (!enable || !MASTER_SCL) begin
                sync_pull <= 1'b0;
                low_cnt <= 16'h0000;
                high_cnt <= 16'h0000;
            end else if (scl_fall) begin
                sync_pull <= 1'b1;
                low_cnt <= 16'(LOW_CYC);
            end else if (sync_pull) begin
                if (low_cnt > 16'h0001) begin
                    low_cnt <= low_cnt - 16'h0001;
                end else begin
                    sync_pull <= 1'b0;
                    high_cnt <= 16'(HIGH_CYC);
                end
            end else if (scl && high_cnt != 16'h0000) begin
                high_cnt <= high_cnt - 16'h0001;
                sync_pull <= high_cnt == 16'h0001;
                low_cnt <= 16'(LOW_CYC);
            end
        end
    end

    // open-drain: only ever drive zero
    wire drive_sda = enable & (ack_drive | (tx_drive & ~tx_bit));
    wire drive_scl = enable & (sync_pull | (hold & phase != twi_pkg::ST_IDLE));
    assign PINS = '{scl_o: 1'b0, scl_oe: drive_scl, sda_o: 1'b0, sda_oe: drive_sda};
    assign BUS_ACTIVE = phase != twi_pkg::ST_IDLE;

    property idle_release;
        @(posedge CLOCK) disable iff (RST)
        (phase == twi_pkg::ST_IDLE && !sync_pull) |-> !PINS.sda_oe && !PINS.scl_oe;
    endproperty
    idle_lines_a: assert property (idle_release) else $error("line driven in idle");
    start_flag_a: assert property (@(posedge CLOCK) disable iff (RST)
        CE && enable && start_cond |=> START_SEEN) else $error("start missed");
    stop_idle_a: assert property (@(posedge CLOCK) disable iff (RST)
        CE && enable && stop_cond |=> phase == twi_pkg::ST_IDLE) else $error("stop missed");
    sda_stable_a: assert property (@(posedge CLOCK) disable iff (RST)
        scl && scl_q && CE && !start_cond |=> $stable(tx_bit) || !tx_drive)
        else $error("sda moved with scl high");
    hold_scl_a: assert property (@(posedge CLOCK) disable iff (RST)
        enable && hold && phase != twi_pkg::ST_IDLE |-> PINS.scl_oe)
        else $error("hold ignored");
    disabled_quiet_a: assert property (@(posedge CLOCK) disable iff (RST)
        !enable |-> !PINS.scl_oe && !PINS.sda_oe) else $error("active while off");
    lost_to_slave_a: assert property (@(posedge CLOCK) disable iff (RST)
        CE && enable && lost && !stop_cond |=> phase == twi_pkg::ST_ADDR)
        else $error("no switch to slave");
    nack_release_a: assert property (@(posedge CLOCK) disable iff (RST)
        !ack_drive && !tx_drive |-> !PINS.sda_oe) else $error("sda held on decline");
    open_drain_a: assert property (@(posedge CLOCK) disable iff (RST)
        PINS.sda_o == 1'b0 && PINS.scl_o == 1'b0) else $error("driving high");

    // address byte complete: eighth falling edge, no bus condition pending
    sequence addr_done;
        CE && enable && phase == twi_pkg::ST_ADDR && scl_fall && bit_cnt == 4'h8
            && !start_cond && !stop_cond && !lost;
    endsequence
    // acknowledge slot of a read, after the address byte or a data byte
    sequence read_ack_slot;
        CE && enable && phase == twi_pkg::ST_ACK && scl_rise && bit_cnt == 4'h8
            && reading && !start_cond && !stop_cond && !lost;
    endsequence

    addr_ack_a: assert property (@(posedge CLOCK) disable iff (RST)
        addr_done ##0 (ACCEPT && addr_match) |=> ack_drive && RX_VALID && RX.is_addr)
        else $error("matched address not acknowledged");
    addr_decline_a: assert property (@(posedge CLOCK) disable iff (RST)
        addr_done ##0 !(ACCEPT && addr_match) |=> !ack_drive && !RX_VALID)
        else $error("declined address acknowledged");
    ten_header_a: assert property (@(posedge CLOCK) disable iff (RST)
        addr_done ##0 (TEN_BIT && is_ten_hdr && !first_ten && !shift[0]) |=> first_ten)
        else $error("ten-bit header not noted");
    ack_release_a: assert property (@(posedge CLOCK) disable iff (RST)
        CE && ack_drive && scl_fall && bit_cnt == 4'h9 |=> !ack_drive)
        else $error("ack held past slot");
    nack_stop_tx_a: assert property (@(posedge CLOCK) disable iff (RST)
        read_ack_slot ##0 sda |=> !reading)
        else $error("transmit kept after nack");
    count_bound_a: assert property (@(posedge CLOCK) disable iff (RST)
        bit_cnt <= 4'h9)
        else $error("bit counter overran");
    restart_addr_a: assert property (@(posedge CLOCK) disable iff (RST)
        CE && enable && start_cond && !stop_cond |=> phase == twi_pkg::ST_ADDR && bit_cnt == 4'h0)
        else $error("start did not restart address");
    off_idle_a: assert property (@(posedge CLOCK) disable iff (RST)
        CE && !enable |=> phase == twi_pkg::ST_IDLE)
        else $error("engine left running while off");
    rise_sample_a: assert property (@(posedge CLOCK) disable iff (RST)
        CE && enable && scl_rise && bit_cnt < 4'h8 && !start_cond && !stop_cond && !lost
            && (phase == twi_pkg::ST_ADDR || phase == twi_pkg::ST_DATA)
            |=> shift == $past(rx_full))
        else $error("bit not taken on rise");
    sync_low_a: assert property (@(posedge CLOCK) disable iff (RST)
        CE && enable && MASTER_SCL && scl_fall |=> sync_pull)
        else $error("low period not started");
endmodule : twi_slave
